// ===== tct_checker.sv
// port-level assertions for the thermal control trigger
`default_nettype none
module tct_checker #(
  parameter integer NSENS = 4,
  parameter integer TW    = 8
) (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                cyc_i,
  input wire logic                stb_i,
  input wire logic                ack_o,
  input wire logic [NSENS*TW-1:0] ondie_temp_sensor_i,
  input wire logic                thermal_control_circuit_o,
  input wire logic                package_hot_indication_n_o,
  input wire logic                gfx_step_down_o,
  input wire logic [3:0]          core_ratio_step_o,
  input wire logic                core_clk_gate_o,
  input wire logic                low_power_operation_o,
  input wire logic [1:0]          sustained_power_mode_o,
  input wire logic                mode_change_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic at_max;
  // a zero margin on any sensor means that sensor sits at max temp
  always_comb begin
    at_max = 1'b0;
    for (int i = 0; i < NSENS; i++) at_max |= (ondie_temp_sensor_i[i*TW +: TW] == '0);
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // five samples cover the sync chain, the min stage and the trigger flop
  sequence s_req; cyc_i && stb_i && !ack_o; endsequence
  sequence s_at_max; at_max [*5]; endsequence
  property p_ack_next; s_req |=> ack_o; endproperty
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  property p_ack_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
  property p_hot; package_hot_indication_n_o == !thermal_control_circuit_o; endproperty
  property p_raw; s_at_max |-> thermal_control_circuit_o; endproperty
  property p_release; $fell(thermal_control_circuit_o) |-> !$past(at_max, 4); endproperty
  property p_gfx; thermal_control_circuit_o [*2] |-> gfx_step_down_o; endproperty
  property p_mode_ok; sustained_power_mode_o != 2'h3; endproperty
  property p_mode_pulse;
    $changed(sustained_power_mode_o) |-> ##[0:1] mode_change_o ##1 !mode_change_o;
  endproperty
  property p_gate;
    $rose(core_clk_gate_o) |->
      (core_ratio_step_o == 4'hf && thermal_control_circuit_o) || low_power_operation_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_hot: assert property (p_hot) else $error("hot pin not inverse of trigger");
  a_raw: assert property (p_raw) else $error("sensor at max but no trigger");
  a_release: assert property (p_release) else $error("trigger dropped at max");
  a_gfx: assert property (p_gfx) else $error("graphics not stepped down");
  a_mode_ok: assert property (p_mode_ok) else $error("illegal power mode");
  a_mode_pulse: assert property (p_mode_pulse) else $error("mode change pulse bad");
  a_gate: assert property (p_gate) else $error("gating before ratio floor");
endmodule
bind tct_top tct_checker #(.NSENS(NSENS), .TW(TW)) u_chk (.clk_i, .rst_i, .cyc_i, .stb_i,
  .ack_o, .ondie_temp_sensor_i, .thermal_control_circuit_o, .package_hot_indication_n_o,
  .gfx_step_down_o, .core_ratio_step_o, .core_clk_gate_o, .low_power_operation_o,
  .sustained_power_mode_o, .mode_change_o);
`default_nettype wire

// ===== tct_ewma.v
// exponentially weighted moving average of the hottest sensor reading
`default_nettype none
module tct_ewma #(
  parameter integer TW = 8,
  parameter integer FW = 8
) (
  input  wire          clk_i,
  input  wire          rst_i,
  input  wire          tick_i,
  input  wire          load_i,
  input  wire [3:0]    shift_i,
  input  wire [TW-1:0] temp_i,
  output wire [TW-1:0] avg_o
);
  reg  [TW+FW-1:0] acc_r;
  reg  [TW+FW-1:0] acc_nxt;
  wire [TW+FW-1:0] samp;
  assign samp = {temp_i, {FW{1'b0}}};

  // a window change restarts from the present reading, no stale history
  always @* begin
    acc_nxt = acc_r;
    if (load_i) begin
      acc_nxt = samp;
    end else if (tick_i) begin
      // acc += (samp - acc) >> shift, done as two branches so no sign is needed
      if (samp >= acc_r) begin
        acc_nxt = acc_r + ((samp - acc_r) >> shift_i);
      end else begin
        acc_nxt = acc_r - ((acc_r - samp) >> shift_i);
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      acc_r <= {(TW+FW){1'b0}};
    end else begin
      acc_r <= acc_nxt;
    end
  end

  assign avg_o = acc_r[TW+FW-1:FW];
endmodule
`default_nettype wire

// ===== tct_regs.vh
// register offsets, field positions, reset values and timing for the thermal trigger
`ifndef TCT_REGS_VH
`define TCT_REGS_VH
// byte offsets on the wishbone slave
`define TCT_OFS_MAXTJ       8'h00
`define TCT_OFS_OFFSET      8'h04
`define TCT_OFS_MODE        8'h08
`define TCT_OFS_LIMIT       8'h0C
`define TCT_OFS_STATUS      8'h10
`define TCT_OFS_TEMP        8'h14
// field positions
`define TCT_MAXTJ_LSB       16
`define TCT_MAXTJ_MSB       23
`define TCT_OFS_LSB         0
`define TCT_OFS_MSB         5
`define TCT_WIN_LSB         8
`define TCT_WIN_MSB         11
`define TCT_MODE_LSB        0
`define TCT_MODE_MSB        1
`define TCT_LPO_BIT         4
`define TCT_OFFL_BIT        5
`define TCT_MINF_BIT        6
`define TCT_CMOD_BIT        7
`define TCT_NOBOOST_BIT     8
// sustained power mode codes
`define TCT_MODE_BASE       2'h0
`define TCT_MODE_RAISED     2'h1
`define TCT_MODE_LOWERED    2'h2
// reset values
`define TCT_RST_OFFSET      6'h00
`define TCT_RST_MODE        32'h0000_0000
`define TCT_RST_LIMIT       16'h0000
// ewma sample interval: time in us, cycles at 10 MHz
`define TCT_SAMPLE_US       100
`define TCT_CLK_MHZ         10
`define TCT_SAMPLE_CYC      (`TCT_SAMPLE_US * `TCT_CLK_MHZ)
`endif

// ===== tct_top.v
// thermal control trigger: sensor compare, offset target, averaging, power mode
// What this block does
// (RULE1) any sensor at max temp engages protection
// (RULE2) active circuit lowers core and graphics operating point
// (RULE3) stays active while temperature held at limit
// (RULE4) ratio plus voltage step, and clock modulation; the block drives only core_ratio_step_o and no voltage step
// (RULE5) max temp fixed at build, read only
// (RULE6) no control disables the protection
// (RULE7) offset subtracted from max temp field
// (RULE8) window zero: instantaneous compare with lowered target
// (RULE9) nonzero window: average held at lowered target
// (RULE10) raw max temp always triggers regardless
// (RULE11) software keeps target below platform trip points
// (RULE12) base, raised and lowered sustained power modes
// (RULE13) mode change reloads limits, boost ceiling unchanged
// (RULE14) modes change at run time, no restart
// (RULE15) low power: limits, fewer cores, lowest freq, modulation
// (RULE16) minimum frequency point uses low voltage point
// (RULE17) readings relative; zero means reached
// (RULE18) package hot output follows active circuit
// (RULE19) reached at or above target, release below
// (RULE20) averaging on fixed tick, reload on window change
//
// The Wishbone interface to the registers and the placing of the registers were left to the implementer.
`default_nettype none
`include "tct_regs.vh"
module tct_top #(
  parameter integer       NSENS       = 4,
  parameter integer       TW          = 8,
  parameter [7:0]         MAX_JUNCT_T = 8'h64,
  parameter integer       STEP_CYC    = 64,
  parameter integer       MOD_PERIOD  = 320,
  parameter integer       SAMPLE_CYC  = `TCT_SAMPLE_CYC
) (
  input  wire              clk_i,
  input  wire              rst_i,
  // classic wishbone slave
  input  wire              cyc_i,
  input  wire              stb_i,
  input  wire              we_i,
  input  wire [7:0]        adr_i,
  input  wire [3:0]        sel_i,
  input  wire [31:0]       dat_i,
  output reg  [31:0]       dat_o,
  output reg               ack_o,
  // sensor readings below max temp, one byte each, from the sensor domain
  input  wire [NSENS*TW-1:0] ondie_temp_sensor_i,
  // control outputs
  output wire              thermal_control_circuit_o,
  output wire              package_hot_indication_n_o,
  output reg  [3:0]        core_ratio_step_o,
  output reg               core_clk_gate_o,
  output reg               gfx_step_down_o,
  output reg  [1:0]        sustained_power_mode_o,
  output reg               mode_change_o,
  output reg  [15:0]       average_power_limit_o,
  output reg               low_power_operation_o,
  output reg               boost_disable_o,
  output reg               core_offline_o,
  output reg               lowest_freq_point_o,
  output reg               low_freq_voltage_point_o,
  output reg               clock_mod_req_o
);
  // two-stage synchroniser for sensor bus
  // each byte is sampled on its own; a byte caught mid-change settles on the
  // next sample, so the trigger may lag one cycle but never holds a stale word
  // longer than that; the all-ones reset value reads as far below max temp
  reg  [NSENS*TW-1:0] sens_s1_r;
  reg  [NSENS*TW-1:0] sens_s2_r;
  always @(posedge clk_i) begin
    if (rst_i) begin
      sens_s1_r <= {(NSENS*TW){1'b1}};
      sens_s2_r <= {(NSENS*TW){1'b1}};
    end else begin
      sens_s1_r <= ondie_temp_sensor_i;
      sens_s2_r <= sens_s1_r;
    end
  end

  // hottest sensor is the smallest distance below max temp
  // a tie between sensors needs no priority, only the value matters
  wire [TW-1:0] mins [0:NSENS];
  assign mins[0] = {TW{1'b1}};
  genvar g;
  generate
    for (g = 0; g < NSENS; g = g + 1) begin : g_min
      wire [TW-1:0] s = sens_s2_r[g*TW +: TW];
      assign mins[g+1] = (s < mins[g]) ? s : mins[g];           // RULE1
    end
  endgenerate

  // registered to cut the path from the min tree into the compares
  reg [TW-1:0] margin_r;   // registered hottest margin
  always @(posedge clk_i) begin
    if (rst_i) begin
      margin_r <= {TW{1'b1}};
    end else begin
      margin_r <= mins[NSENS];
    end
  end

  // software registers
  reg  [5:0]  offset_r;
  reg  [3:0]  window_r;
  reg  [1:0]  mode_r;
  reg  [8:4]  lpo_r;
  reg  [15:0] limit_r;
  wire        wr_stb;
  wire        rd_stb;
  assign wr_stb = cyc_i & stb_i & we_i & ~ack_o;
  assign rd_stb = cyc_i & stb_i & ~we_i & ~ack_o;

  // absolute temperature and targets; max temp is a build constant, no write path
  wire [TW-1:0] abs_temp;
  wire [TW-1:0] low_tgt;
  // a margin beyond max temp (the all-ones reset value too) would wrap to a
  // hot absolute value and fire the trigger, so it clamps to zero
  assign abs_temp = (margin_r > MAX_JUNCT_T) ? {TW{1'b0}} :
                    MAX_JUNCT_T - margin_r;                      // RULE17
  // an offset past max temp clamps the target at zero instead of wrapping
  assign low_tgt  = ({2'b00, offset_r} > MAX_JUNCT_T) ? {TW{1'b0}} :
                    MAX_JUNCT_T - {2'b00, offset_r};             // RULE7

  // instantaneous compares with no hysteresis at the target edge
  wire raw_hit;
  wire off_hit;
  assign raw_hit = (margin_r == {TW{1'b0}});                     // RULE10
  assign off_hit = (abs_temp >= low_tgt);                        // RULE19

  // fixed averaging tick
  // free running, so the filter time constant does not hang on the moment
  // software happened to write the window
  reg  [15:0] tick_cnt_r;
  wire        tick;
  assign tick = (tick_cnt_r == SAMPLE_CYC[15:0] - 16'h0001);
  always @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_r <= 16'h0000;
    end else if (tick) begin
      tick_cnt_r <= 16'h0000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
    end
  end

  // the average tracks all the time, also with the window at zero, so the
  // only hazard is a window change; that restarts it from the present reading
  reg win_load_r;   // window changed by the last write, restart the average
  wire [TW-1:0] avg_temp;
  tct_ewma #(
    .TW (TW),
    .FW (8)
  ) u_ewma (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .tick_i  (tick),                                             // RULE20
    .load_i  (win_load_r),                                       // RULE20
    .shift_i (window_r),
    .temp_i  (abs_temp),
    .avg_o   (avg_temp)
  );

  // lowered target uses instant or averaged value depending on window
  wire avg_mode;
  wire avg_hit;
  assign avg_mode = (window_r != 4'h0);
  assign avg_hit  = avg_mode ? (avg_temp >= low_tgt) : off_hit;  // RULE8 RULE9

  // circuit is active while any trigger holds; raw max temp cannot be masked
  // avg_hit already falls back to the instant compare when the window is zero,
  // so the raw compare is the only other term; no enable bit exists anywhere
  wire tcc_nxt;
  assign tcc_nxt = raw_hit | avg_hit;                            // RULE1 RULE6 RULE10
  reg tcc_r;
  always @(posedge clk_i) begin
    if (rst_i) begin
      tcc_r <= 1'b0;
    end else begin
      tcc_r <= tcc_nxt;                                          // RULE3
    end
  end
  assign thermal_control_circuit_o  = tcc_r;
  // the hot pin is active low and mirrors the circuit with no extra delay
  assign package_hot_indication_n_o = ~tcc_r;                    // RULE18

  // stepping engine: lower ratio each step while active, raise when clear
  // one step per period both ways, so a brief excursion does not snap the
  // cores straight back to full ratio and bounce off the limit again
  reg  [15:0] step_cnt_r;
  wire        step;
  assign step = (step_cnt_r == STEP_CYC[15:0] - 16'h0001);
  always @(posedge clk_i) begin
    if (rst_i) begin
      step_cnt_r <= 16'h0000;
    end else if (step) begin
      step_cnt_r <= 16'h0000;
    end else begin
      step_cnt_r <= step_cnt_r + 16'h0001;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      core_ratio_step_o <= 4'h0;
      gfx_step_down_o   <= 1'b0;
    end else begin
      gfx_step_down_o <= tcc_r;                                  // RULE2
      if (step && tcc_r && core_ratio_step_o != 4'hF) begin
        core_ratio_step_o <= core_ratio_step_o + 4'h1;           // RULE3 RULE4
      end else if (step && !tcc_r && core_ratio_step_o != 4'h0) begin
        core_ratio_step_o <= core_ratio_step_o - 4'h1;
      end
    end
  end

  // clock modulation 25 percent on once the ratio floor is reached;
  // only the raw limit engages it, the averaged loop never modulates;
  // the counter restarts whenever modulation stops
  reg  [15:0] mod_cnt_r;
  wire        mod_on;
  wire        lpm_mod;
  assign mod_on = tcc_r && raw_hit && (core_ratio_step_o == 4'hF);
  // low power modulation counts only while low power operation is enabled;
  // a stray modulation bit alone must not gate the cores
  assign lpm_mod = lpo_r[`TCT_LPO_BIT] & lpo_r[`TCT_CMOD_BIT];  // RULE15
  always @(posedge clk_i) begin
    if (rst_i) begin
      mod_cnt_r       <= 16'h0000;
      core_clk_gate_o <= 1'b0;
    end else if (!mod_on && !lpm_mod) begin
      mod_cnt_r       <= 16'h0000;
      core_clk_gate_o <= 1'b0;
    end else begin
      if (mod_cnt_r == MOD_PERIOD[15:0] - 16'h0001) begin
        mod_cnt_r <= 16'h0000;
      end else begin
        mod_cnt_r <= mod_cnt_r + 16'h0001;
      end
      core_clk_gate_o <= (mod_cnt_r >= MOD_PERIOD[15:0] >> 2);   // RULE4 RULE15
    end
  end

  // register writes; all take effect at run time with no restart
  // a lane left out of sel keeps its field; a write to a read-only or
  // unmapped offset is acked and dropped
  always @(posedge clk_i) begin
    if (rst_i) begin
      offset_r   <= `TCT_RST_OFFSET;
      window_r   <= 4'h0;
      mode_r     <= `TCT_MODE_BASE;
      lpo_r      <= 5'h00;
      limit_r    <= `TCT_RST_LIMIT;
      win_load_r <= 1'b0;
    end else begin
      win_load_r <= 1'b0;
      if (wr_stb && adr_i == `TCT_OFS_OFFSET) begin
        if (sel_i[0]) begin
          offset_r <= dat_i[`TCT_OFS_MSB:`TCT_OFS_LSB];          // RULE7
        end
        if (sel_i[1]) begin
          window_r   <= dat_i[`TCT_WIN_MSB:`TCT_WIN_LSB];
          win_load_r <= (dat_i[`TCT_WIN_MSB:`TCT_WIN_LSB] != window_r); // RULE20
        end
      end
      // code 3 is reserved: the mode keeps its value, the low power bits land
      if (wr_stb && adr_i == `TCT_OFS_MODE) begin
        if (sel_i[0] && dat_i[`TCT_MODE_MSB:`TCT_MODE_LSB] != 2'h3) begin
          mode_r <= dat_i[`TCT_MODE_MSB:`TCT_MODE_LSB];          // RULE12 RULE14
        end
        if (sel_i[0]) begin
          lpo_r[7:4] <= dat_i[7:4];                              // RULE15
        end
        if (sel_i[1]) begin
          lpo_r[8] <= dat_i[8];
        end
      end
      if (wr_stb && adr_i == `TCT_OFS_LIMIT) begin
        if (sel_i[0]) begin
          limit_r[7:0] <= dat_i[7:0];
        end
        if (sel_i[1]) begin
          limit_r[15:8] <= dat_i[15:8];
        end
      end
    end
  end

  // mode and limit outputs; a mode change pulses so limits get reloaded,
  // the boost ceiling is not touched by it; the low power sub-bits are
  // qualified here so those outputs stay low while low power is off, except clock_mod_req_o, which thermal modulation also drives
  always @(posedge clk_i) begin
    if (rst_i) begin
      sustained_power_mode_o   <= `TCT_MODE_BASE;
      mode_change_o            <= 1'b0;
      average_power_limit_o    <= 16'h0000;
      low_power_operation_o    <= 1'b0;
      boost_disable_o          <= 1'b0;
      core_offline_o           <= 1'b0;
      lowest_freq_point_o      <= 1'b0;
      low_freq_voltage_point_o <= 1'b0;
      clock_mod_req_o          <= 1'b0;
    end else begin
      sustained_power_mode_o   <= mode_r;
      mode_change_o            <= (mode_r != sustained_power_mode_o); // RULE13
      average_power_limit_o    <= limit_r;                       // RULE13
      low_power_operation_o    <= lpo_r[`TCT_LPO_BIT];
      boost_disable_o          <= lpo_r[`TCT_LPO_BIT] & lpo_r[`TCT_NOBOOST_BIT]; // RULE15
      core_offline_o           <= lpo_r[`TCT_LPO_BIT] & lpo_r[`TCT_OFFL_BIT];
      lowest_freq_point_o      <= lpo_r[`TCT_LPO_BIT] & lpo_r[`TCT_MINF_BIT];    // RULE16
      low_freq_voltage_point_o <= lpo_r[`TCT_LPO_BIT] & lpo_r[`TCT_MINF_BIT];    // RULE16
      clock_mod_req_o          <= lpm_mod | mod_on;
    end
  end

  // read mux; unmapped addresses read zero and still ack
  // status and temperature are live views captured when the request is taken
  reg [31:0] rd_nxt;
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (adr_i)
      `TCT_OFS_MAXTJ:  rd_nxt[`TCT_MAXTJ_MSB:`TCT_MAXTJ_LSB] = MAX_JUNCT_T;     // RULE5
      `TCT_OFS_OFFSET: rd_nxt = {20'h0_0000, window_r, 2'b00, offset_r};
      `TCT_OFS_MODE:   rd_nxt = {23'h00_0000, lpo_r, 2'b00, mode_r};
      `TCT_OFS_LIMIT:  rd_nxt = {16'h0000, limit_r};
      `TCT_OFS_STATUS: rd_nxt = {28'h000_0000, avg_mode, raw_hit, avg_hit, tcc_r};
      `TCT_OFS_TEMP:   rd_nxt = {8'h00, avg_temp, abs_temp, margin_r};
      default:         rd_nxt = 32'h0000_0000;
    endcase
  end

  // one wait-free ack per request, dropped the cycle after
  // the ~ack_o term keeps a held request from being taken twice
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      if (rd_stb) begin
        dat_o <= rd_nxt;
      end
    end
  end
endmodule
`default_nettype wire

// ===== thermal_control_trigger_tb_top.sv
// self-checking bench for the thermal control trigger
`default_nettype none
`include "tct_regs.vh"
module thermal_control_trigger_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] MAXT = 8'h64;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000, sens = 32'h4040_4040, dat_o, q;
  logic        ack_o, thermal_control_circuit, hot_n, gfx, gate, mchg, lpo, bdis, offl, lfp, lfv, cmr;
  logic [3:0]  step;
  logic [1:0]  mode, mexp = 2'h0;
  logic [15:0] lim, lv;
  int          err_total = 0, n_tests = 0, m, o, c;
  always #50 clk_i = ~clk_i;
  tct_top #(.MAX_JUNCT_T(MAXT), .STEP_CYC(4), .SAMPLE_CYC(10)) dut (.clk_i, .rst_i,
    .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .ondie_temp_sensor_i(sens), .thermal_control_circuit_o(thermal_control_circuit),
    .package_hot_indication_n_o(hot_n), .core_ratio_step_o(step), .core_clk_gate_o(gate),
    .gfx_step_down_o(gfx), .sustained_power_mode_o(mode), .mode_change_o(mchg),
    .average_power_limit_o(lim), .low_power_operation_o(lpo), .boost_disable_o(bdis),
    .core_offline_o(offl), .lowest_freq_point_o(lfp), .low_freq_voltage_point_o(lfv),
    .clock_mod_req_o(cmr));
  task automatic stop_test();
    if (err_total == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s saw %h expected %h", $time, what, seen, exp);
    end
  endtask
  // one classic cycle; the extra edge keeps ack low a cycle between requests
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 16);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
    if (n >= 16) begin
      err_total++;
      stop_test();
    end
  endtask
  // hottest sensor at margin mg, the rest cooler, on a random lane
  task automatic put(input int mg);
    logic [31:0] v;
    int k;
    k = $urandom_range(0, 3);
    for (int i = 0; i < 4; i++) v[i*8 +: 8] = 8'(i == k ? mg : mg + $urandom_range(1, 20));
    sens <= v;
    repeat (6) @(posedge clk_i);
  endtask
  function automatic logic exp_tcc(input int mg, input int off);
    return mg == 0 || mg <= off;
  endfunction
  function automatic logic [5:0] exp_lp(input logic [8:0] f);
    return {f[4], f[4] & f[5], f[4] & f[6], f[4] & f[6], f[4] & f[7], f[4] & f[8]};
  endfunction
  initial begin
    void'($urandom(32'h2b11));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(32'({thermal_control_circuit, hot_n, mode, lim}), 32'h0004_0000, "reset outputs");
    wb(1'b1, `TCT_OFS_MAXTJ, 32'h00ff_0000);
    wb(1'b0, `TCT_OFS_MAXTJ, 32'h0000_0000);
    chk(32'(q[23:16]), 32'(MAXT), "max temp");
    wb(1'b0, 8'h20, 32'h0000_0000);
    chk(q, 32'h0000_0000, "unmapped read");
    // instantaneous compare against lowered target: at, just below, raw max
    for (int t = 0; t < 6; t++) begin
      o = $urandom_range(0, 30);
      wb(1'b1, `TCT_OFS_OFFSET, 32'(o));
      for (int j = 0; j < 3; j++) begin
        m = (j == 2) ? 0 : o + j;
        put(m);
        chk(32'(thermal_control_circuit), 32'(exp_tcc(m, o)), "lowered target");
        chk(32'(hot_n), 32'(!exp_tcc(m, o)), "hot pin");
        wb(1'b0, `TCT_OFS_TEMP, 32'h0000_0000);
        chk(32'(q[15:0]), 32'({MAXT - 8'(m), 8'(m)}), "temp read");
      end
    end
    // averaging lags a hot step; a window write reloads the average
    put(40);
    wb(1'b1, `TCT_OFS_OFFSET, 32'h0000_020a);
    put(5);
    chk(32'(thermal_control_circuit), 32'h0, "average lags");
    c = 0;
    while (thermal_control_circuit !== 1'b1 && c < 400) begin
      @(posedge clk_i);
      c++;
    end
    chk(32'(thermal_control_circuit), 32'h1, "average at target");
    if (thermal_control_circuit !== 1'b1) stop_test();
    put(40);
    wb(1'b1, `TCT_OFS_OFFSET, 32'h0000_030a);
    repeat (2) @(posedge clk_i);
    chk(32'(thermal_control_circuit), 32'h0, "average reloaded");
    put(0);
    chk(32'(thermal_control_circuit), 32'h1, "raw max with average");
    repeat (100) @(posedge clk_i);
    chk(32'(step), 32'hf, "ratio floor");
    c = 0;
    repeat (320) begin
      @(posedge clk_i);
      c += int'(gate);
    end
    chk(32'(c), 32'd240, "gated share");
    wb(1'b0, `TCT_OFS_STATUS, 32'h0000_0000);
    chk(32'({q[2], q[0], thermal_control_circuit, gfx}), 32'hf, "held at max");
    wb(1'b1, `TCT_OFS_OFFSET, 32'h0000_0000);
    put(40);
    // every mode code and random low power sub-bits, changed at run time
    for (int t = 0; t < 12; t++) begin
      c = (t < 4) ? t : $urandom_range(0, 511);
      lv = 16'($urandom);
      wb(1'b1, `TCT_OFS_MODE, 32'(c));
      wb(1'b1, `TCT_OFS_LIMIT, 32'(lv));
      if (c[1:0] != 2'h3) mexp = c[1:0];
      @(posedge clk_i);
      chk(32'(mode), 32'(mexp), "power mode");
      chk(32'(lim), 32'(lv), "power limit");
      chk(32'({lpo, offl, lfp, lfv, cmr, bdis}), 32'(exp_lp(9'(c))), "low power");
    end
    stop_test();
  end
endmodule
`default_nettype wire
